// *** src/seq_event_consts.vh ***
`ifndef SEQ_EVENT_CONSTS_VH
`define SEQ_EVENT_CONSTS_VH
// command word fields
`define OPC_HI          31
`define OPC_LO          28
`define OR_BIT          27
`define INV_BIT         26
`define EVT_HI          25
`define SEC_HI          10
// instruction codes
`define OPC_CLEAR       4'h0
`define OPC_WAIT        4'h2
`define OPC_LATE        4'h3
`define OPC_UPLOAD      4'h4
`define OPC_SET         4'h5
// event vector layout
`define EVT_W           26
`define SEC_W           11
`define EVT_ZERO        26'h0000000
`define SEC_ZERO        11'h000
// event bit positions of pins, command-only signals and hardware edge sources
`define EVT_PIN_LO      17
`define EVT_SIG_LO      21
`define SIG_W           5
`define PIN_W           4
`define HW_MASK         26'h001ff7f
`define SIG_MASK        26'h3e00000
// timeout counter
`define TO_W            16
`define TO_ZERO         16'h0000
`define TO_ONE          16'h0001
// dword address step
`define ADDR_STEP       32'h00000004
`define ADDR_ZERO       32'h00000000
`endif

// *** src/sequencer_event_command_unit.v ***
// What this block does
// - event sets on rise, clears on fall
// - edge source high from reset leaves its event clear; pin events still follow the level
// - four pin events follow pin levels
// - five general signal events, index 0-4
// - three video transfer done events
// - odd and even field events per port
// - scaler source and target line events
// - opcode bits 31-28, field bits 27-0
// - wait stalls until condition or timeout
// - timeout counts clocks and/or vertical syncs
// - timeout sets flag, interrupt request, halts
// - or select picks or, else and
// - invert waits for condition false
// - upload copies selected register sections
// - upload moves only changed registers
// - check late flags already-true, else waits
// - clear touches only private event copies
// - copy set again by set or rise
// - no-operation is clear with nothing selected
// - set touches only private event copies
// - reset clears every task enable
// - two like tasks, task 0 first at the shared fetch port
`timescale 1ns/1ns
`include "seq_event_consts.vh"
module sequencer_event_command_unit
(
   input  wire         clock_i,
   input  wire         rst_n_i,
   input  wire [25:0]  event_source_i,      // hardware event sources in command bit order
   input  wire [1:0]   task_enable_set_i,   // pulse: software enables task
   input  wire [1:0]   task_enable_clr_i,   // pulse: software disables task
   input  wire [31:0]  list_addr0_i,        // start address task 0
   input  wire [31:0]  list_addr1_i,        // start address task 1
   input  wire [15:0]  timeout0_i,          // timeout limit task 0, zero disables
   input  wire [15:0]  timeout1_i,          // timeout limit task 1, zero disables
   input  wire [1:0]   timeout_clk_en_i,    // per task: count clocks
   input  wire [1:0]   timeout_vs_en_i,     // per task: count vertical syncs
   input  wire         vsync_pulse_i,       // one-cycle vertical sync pulse
   input  wire [1:0]   late_clr_i,          // pulse: clear late flag
   input  wire [1:0]   timeout_clr_i,       // pulse: clear timeout flag
   input  wire         fetch_ready_i,       // memory answers a fetch
   input  wire [31:0]  fetch_data_i,        // fetched dword
   input  wire [10:0]  section_changed_i,   // shadow section differs from working copy
   output reg          fetch_req_o,         // fetch request level
   output reg  [31:0]  fetch_addr_o,        // fetch byte address
   output reg          fetch_task_o,        // task owning the fetch
   output reg  [10:0]  upload_strobe_o,     // pulse: copy this section
   output reg  [25:0]  event_copy_o,        // private event copies
   output reg  [1:0]   task_enable_o,       // task enable bits
   output reg  [1:0]   task_timeout_flag_o, // timeout flags
   output reg  [1:0]   task_late_flag_o,    // late flags
   output reg  [1:0]   timeout_irq_o        // pulse: timeout interrupt request
);
   // task states: stopped, fetching the next dword, stalled on a condition
   localparam ST_IDLE  = 2'b00;
   localparam ST_FETCH = 2'b01;
   localparam ST_WAIT  = 2'b10;

   ////////////////////////////////////////////////////////////////////////////
   // edge detection of sources
   reg  [25:0] src_q;
   wire [25:0] rise = event_source_i & ~src_q & `HW_MASK;
   wire [25:0] fall = ~event_source_i & src_q & `HW_MASK;

   // the copy of the sources starts low, so a source already high at reset release
   // would look like a rise; primed_q keeps edges out until the first sample is in
   reg         primed_q;

   // last source levels and the primed mark
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         src_q    <= `EVT_ZERO;
         primed_q <= 1'b0;
      end
      else
      begin
         src_q    <= event_source_i;
         primed_q <= 1'b1;
      end
   end

   // edges take effect only once primed
   wire [25:0] edge_set = rise & {26{primed_q}};
   wire [25:0] edge_clr = fall & {26{primed_q}};

   ////////////////////////////////////////////////////////////////////////////
   // per task state
   reg  [1:0]  st_q  [0:1];
   reg  [31:0] pc_q  [0:1];
   reg  [31:0] cmd_q [0:1];
   reg  [15:0] to_q  [0:1];
   reg         gnt_q;                  // task whose fetch is outstanding

   // effects of the command word taken in this cycle
   reg  [25:0] set_req;
   reg  [25:0] clr_req;
   reg  [10:0] upl_d;

   // condition evaluation for a command word: and needs every selected copy set,
   // or needs any one of them; invert turns the result over
   function cond_true;
      input [31:0] c;
      input [25:0] ev;
      reg   [25:0] sel;
      reg          r;
      begin
         sel = c[`EVT_HI:0];
         if (c[`OR_BIT])
            r = |(ev & sel);
         else
            r = &(ev | ~sel);
         cond_true = r ^ c[`INV_BIT];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // event copies: command set/clear, hardware edges, pin levels
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         event_copy_o <= `EVT_ZERO;
      else
      begin
         // commands only touch copies; edges of the real source win, so a rise
         // in the same cycle as a clear command still sets the copy
         event_copy_o <= ((event_copy_o | set_req) & ~clr_req & ~edge_clr)
                         | edge_set;
         // pin events follow the pin level, no edge needed
         event_copy_o[`EVT_PIN_LO+`PIN_W-1:`EVT_PIN_LO] <=
            event_source_i[`EVT_PIN_LO+`PIN_W-1:`EVT_PIN_LO];
         // signal events answer only to set and clear commands
         event_copy_o[`EVT_SIG_LO+`SIG_W-1:`EVT_SIG_LO] <=
            (event_copy_o[`EVT_SIG_LO+`SIG_W-1:`EVT_SIG_LO] | set_req[`EVT_SIG_LO+`SIG_W-1:`EVT_SIG_LO])
            & ~clr_req[`EVT_SIG_LO+`SIG_W-1:`EVT_SIG_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command effects decided this cycle (set/clear/upload)
   // only the word taken in this cycle has an effect
   always @*
   begin
      // defaults: no set, no clear, no upload
      set_req = `EVT_ZERO;
      clr_req = `EVT_ZERO;
      upl_d   = `SEC_ZERO;
      if (fetch_req_o && fetch_ready_i)
      begin
         case (fetch_data_i[`OPC_HI:`OPC_LO])
            `OPC_CLEAR:  clr_req = fetch_data_i[`EVT_HI:0];
            `OPC_SET:    set_req = fetch_data_i[`EVT_HI:0];
            `OPC_UPLOAD: upl_d   = fetch_data_i[`SEC_HI:0] & section_changed_i;
            // wait and check-late act through the task logic; other codes do nothing
            default:     upl_d   = `SEC_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fetch arbitration: task 0 first, then task 1; one fetch is outstanding at a
   // time, and its request and address stand until the memory answers
   wire want0 = (st_q[0] == ST_FETCH);
   wire want1 = (st_q[1] == ST_FETCH);
   wire busy  = fetch_req_o;
   wire pick  = want0 ? 1'b0 : 1'b1;

   // request drops the edge after the answer; upload strobes last one cycle
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         fetch_req_o     <= 1'b0;
         fetch_addr_o    <= `ADDR_ZERO;
         fetch_task_o    <= 1'b0;
         gnt_q           <= 1'b0;
         upload_strobe_o <= `SEC_ZERO;
      end
      else
      begin
         upload_strobe_o <= upl_d;
         if (busy && fetch_ready_i)
            fetch_req_o <= 1'b0;
         else if (!busy && (want0 || want1))
         begin
            fetch_req_o  <= 1'b1;
            gnt_q        <= pick;
            fetch_task_o <= pick;
            fetch_addr_o <= pick ? pc_q[1] : pc_q[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per task sequencing, one instance per task; both tasks behave alike and
   // share only the fetch port, where task 0 always wins, so task 0 can hold task 1 up
   genvar t;
   generate
      for (t = 0; t < 2; t = t + 1)
      begin : g_task
         // this task's share of the fetch answer, limit and timeout tick
         wire        got   = fetch_req_o && fetch_ready_i && (gnt_q == t) && (st_q[t] == ST_FETCH);
         wire [3:0]  opc   = fetch_data_i[`OPC_HI:`OPC_LO];
         wire [15:0] limit = (t == 0) ? timeout0_i : timeout1_i;
         wire        tick  = (timeout_clk_en_i[t] | (timeout_vs_en_i[t] & vsync_pulse_i));

         // condition of the stalled command, and expiry on this tick
         wire        wok   = cond_true(cmd_q[t], event_copy_o);
         wire        expd  = (limit != `TO_ZERO) && tick && (to_q[t] + `TO_ONE >= limit);

         always @(posedge clock_i or negedge rst_n_i)
         begin
            // a reset leaves every task stopped until software starts it
            if (!rst_n_i)
            begin
               st_q[t]                <= ST_IDLE;
               pc_q[t]                <= `ADDR_ZERO;
               cmd_q[t]               <= `ADDR_ZERO;
               to_q[t]                <= `TO_ZERO;
               task_enable_o[t]       <= 1'b0;
               task_timeout_flag_o[t] <= 1'b0;
               task_late_flag_o[t]    <= 1'b0;
               timeout_irq_o[t]       <= 1'b0;
            end
            else
            begin
               timeout_irq_o[t] <= 1'b0;

               // flag clears come first, so a set further down in the same cycle wins
               if (timeout_clr_i[t])
                  task_timeout_flag_o[t] <= 1'b0;
               if (late_clr_i[t])
                  task_late_flag_o[t] <= 1'b0;

               // idle waits for a start, fetch takes dwords, wait stalls on a condition
               case (st_q[t])
                  ST_IDLE:
                  begin
                     // the start address is taken together with the enable
                     if (task_enable_set_i[t])
                     begin
                        task_enable_o[t] <= 1'b1;
                        pc_q[t]          <= (t == 0) ? list_addr0_i : list_addr1_i;
                        st_q[t]          <= ST_FETCH;
                     end
                  end

                  ST_FETCH:
                  begin
                     if (task_enable_clr_i[t])
                     begin
                        task_enable_o[t] <= 1'b0;
                        st_q[t]          <= ST_IDLE;
                     end
                     else if (got)
                     begin
                        // a one-dword command is done here; the next dword follows on
                        pc_q[t]  <= pc_q[t] + `ADDR_STEP;
                        cmd_q[t] <= fetch_data_i;
                        to_q[t]  <= `TO_ZERO;
                        if (opc == `OPC_WAIT)
                           st_q[t] <= ST_WAIT;
                        else if (opc == `OPC_LATE)
                        begin
                           if (cond_true(fetch_data_i, event_copy_o))
                              task_late_flag_o[t] <= 1'b1;
                           else
                              st_q[t] <= ST_WAIT;
                        end
                     end
                  end

                  // a condition that holds beats a timeout in the same cycle
                  ST_WAIT:
                  begin
                     if (task_enable_clr_i[t])
                     begin
                        task_enable_o[t] <= 1'b0;
                        st_q[t]          <= ST_IDLE;
                     end
                     else if (wok)
                        st_q[t] <= ST_FETCH;
                     else if (expd)
                     begin
                        task_timeout_flag_o[t] <= 1'b1;
                        timeout_irq_o[t]       <= 1'b1;
                        task_enable_o[t]       <= 1'b0;
                        st_q[t]                <= ST_IDLE;
                     end
                     // the counter only runs while a limit is set
                     else if (tick && limit != `TO_ZERO)
                        to_q[t] <= to_q[t] + `TO_ONE;
                  end

                  // an unused state code falls back to idle
                  default:
                     st_q[t] <= ST_IDLE;
               endcase
            end
         end
      end
   endgenerate
endmodule // sequencer_event_command_unit

// *** dv/seq_event_assertions.sv ***
`timescale 1ns/1ns
`include "seq_event_consts.vh"
module seq_event_checker
(
   input wire        clock_i,
   input wire        rst_n_i,
   input wire [25:0] event_source_i,
   input wire [1:0]  task_enable_set_i,
   input wire        fetch_ready_i,
   input wire [10:0] section_changed_i,
   input wire        fetch_req_o,
   input wire [31:0] fetch_addr_o,
   input wire [10:0] upload_strobe_o,
   input wire [25:0] event_copy_o,
   input wire [1:0]  task_enable_o,
   input wire [1:0]  task_timeout_flag_o,
   input wire [1:0]  timeout_irq_o
);
   reg  [25:0] src_q;
   reg  [1:0]  age_q;
   wire [25:0] rise  = event_source_i & ~src_q & `HW_MASK;
   wire [25:0] fall  = ~event_source_i & src_q & `HW_MASK;
   wire        armed = age_q == 2'h3;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////
   // last source levels, and a few cycles of settling after reset
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         src_q <= `EVT_ZERO;
         age_q <= 2'h0;
      end
      else
      begin
         src_q <= event_source_i;
         if (!armed)
            age_q <= age_q + 2'h1;
      end
   end
   ////////////////////////////////////////
   // event copies, fetch handshake, upload, timeout, enable
   rise_sets_a: assert property (armed && |rise |=> (event_copy_o & $past(rise)) == $past(rise))
      else $error("event copy missed a rise");
   fall_clears_a: assert property (armed && |fall |=> (event_copy_o & $past(fall)) == `EVT_ZERO)
      else $error("event copy missed a fall");
   pin_level_a: assert property (armed |-> event_copy_o[20:17] == $past(event_source_i[20:17]))
      else $error("pin event off pin level");
   fetch_hold_a: assert property (fetch_req_o && !fetch_ready_i |=> fetch_req_o && $stable(fetch_addr_o))
      else $error("fetch request not held");
   fetch_drop_a: assert property (fetch_req_o && fetch_ready_i |=> !fetch_req_o)
      else $error("fetch request kept after answer");
   upload_changed_a: assert property (upload_strobe_o != `SEC_ZERO |->
      (upload_strobe_o & ~$past(section_changed_i)) == `SEC_ZERO)
      else $error("unchanged section uploaded");
   timeout_halt_a: assert property (timeout_irq_o[0] |-> ##[0:1] (task_timeout_flag_o[0] && !task_enable_o[0]))
      else $error("timeout without flag or halt");
   irq_pulse_a: assert property (timeout_irq_o[0] |=> !timeout_irq_o[0])
      else $error("timeout request longer than one cycle");
   enable_cause_a: assert property ($rose(task_enable_o[0]) |->
      $past(task_enable_set_i[0]) || $past(task_enable_set_i[0], 2))
      else $error("task enabled without request");
   cover property (upload_strobe_o != `SEC_ZERO);
   cover property (timeout_irq_o[0]);
   cover property (armed && |rise);
endmodule // seq_event_checker
bind sequencer_event_command_unit seq_event_checker seq_event_checker_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .event_source_i(event_source_i), .task_enable_set_i(task_enable_set_i), .fetch_ready_i(fetch_ready_i),
   .section_changed_i(section_changed_i), .fetch_req_o(fetch_req_o), .fetch_addr_o(fetch_addr_o),
   .upload_strobe_o(upload_strobe_o), .event_copy_o(event_copy_o), .task_enable_o(task_enable_o),
   .task_timeout_flag_o(task_timeout_flag_o), .timeout_irq_o(timeout_irq_o));

// *** dv/cmd_memory_model.sv ***
`timescale 1ns/1ns
module cmd_memory_model
(
   input  wire        clock_i,
   input  wire        rst_n_i,
   input  wire [1:0]  lat_i,
   input  wire        fetch_req_i,
   input  wire [31:0] fetch_addr_i,
   output reg         fetch_ready_o,
   output reg  [31:0] fetch_data_o
);
   reg [31:0] mem [0:63];
   reg [1:0]  cnt_q;
   // one dword per request after lat_i cycles; data churns while not valid
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         fetch_ready_o <= 1'b0;
         fetch_data_o  <= 32'h00000000;
         cnt_q         <= 2'h0;
      end
      else if (fetch_req_i && !fetch_ready_o && cnt_q == lat_i)
      begin
         fetch_ready_o <= 1'b1;
         fetch_data_o  <= mem[fetch_addr_i[7:2]];
      end
      else
      begin
         fetch_ready_o <= 1'b0;
         fetch_data_o  <= ~fetch_data_o;
         cnt_q         <= (fetch_req_i && !fetch_ready_o) ? cnt_q + 2'h1 : 2'h0;
      end
   end
endmodule // cmd_memory_model

// *** dv/test_sequencer_event_command_unit.sv ***
`timescale 1ns/1ns
module test_sequencer_event_command_unit;
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [25:0] src = 26'h0020008; // pin 0 and one done source high from reset
   logic [1:0]  en_set = 2'h0, en_clr = 2'h0, late_clr = 2'h0, to_clr = 2'h0, lat = 2'h1;
   logic [31:0] addr1 = 32'h00000000;
   logic [15:0] limit0 = 16'h0000;
   logic [10:0] changed = 11'h000;
   wire         ready, req, owner;
   wire  [31:0] data, addr;
   wire  [10:0] strobe;
   wire  [25:0] copy;
   wire  [1:0]  enable, to_flag, late_flag, irq;
   int          err_count = 0, samples_checked = 0;
   logic [57:0] rows [9] = '{{32'h53e00000, 26'h3e00000}, {32'h01400000, 26'h2a00000},
      {32'h00000000, 26'h2a00000}, {32'h50400000, 26'h2e00000}, {32'h50000002, 26'h2e00002},
      {32'h00000002, 26'h2e00000}, {32'h28200002, 26'h2e00000}, {32'h24200002, 26'h2e00000},
      {32'hf3e00000, 26'h2e00000}};
   sequencer_event_command_unit sequencer_event_command_unit_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .event_source_i(src), .task_enable_set_i(en_set), .task_enable_clr_i(en_clr), .list_addr0_i(32'h0),
      .list_addr1_i(addr1), .timeout0_i(limit0), .timeout1_i(16'h0), .timeout_clk_en_i(2'h3),
      .timeout_vs_en_i(2'h0), .vsync_pulse_i(1'b0), .late_clr_i(late_clr), .timeout_clr_i(to_clr),
      .fetch_ready_i(ready), .fetch_data_i(data), .section_changed_i(changed), .fetch_req_o(req),
      .fetch_addr_o(addr), .fetch_task_o(owner), .upload_strobe_o(strobe), .event_copy_o(copy),
      .task_enable_o(enable), .task_timeout_flag_o(to_flag), .task_late_flag_o(late_flag), .timeout_irq_o(irq));
   cmd_memory_model cmd_memory_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .lat_i(lat),
      .fetch_req_i(req), .fetch_addr_i(addr), .fetch_ready_o(ready), .fetch_data_o(data));
   ////////////////////////////////////////
   // compare, fetch step and closing tasks
   task automatic chk(input string what, input logic [31:0] exp, got);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic hs(input logic [31:0] adr);
      int n;
      n = 0;
      do @(negedge clock_i); while (!(req === 1'b1 && ready === 1'b1) && ++n < 99);
      chk("fetch handshake", 1'b1, req & ready);
      chk("fetch address", adr, addr);
      @(negedge clock_i);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////
   // clock, watchdog and test sequence
   initial forever #4 clock_i = ~clock_i;
   initial
   begin
      #30000;
      err_count++;
      results();
   end
   initial
   begin
      for (int k = 0; k < 9; k++)
         cmd_memory_model_i.mem[k] = rows[k][57:26];
      cmd_memory_model_i.mem[9] = 32'h20000002;
      cmd_memory_model_i.mem[10] = 32'h00000002; // drop transfer-done copy before upload
      cmd_memory_model_i.mem[11] = 32'h400007ff;
      cmd_memory_model_i.mem[12] = 32'h20000002;
      cmd_memory_model_i.mem[13] = 32'h30200000;
      cmd_memory_model_i.mem[14] = 32'h20000004;
      cmd_memory_model_i.mem[32] = 32'h20000001;
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      en_set <= 2'h1;
      @(negedge clock_i);
      chk("held source copy", 1'b0, copy[3]);
      chk("pin copy", 1'b1, copy[17]);
      @(posedge clock_i);
      en_set <= 2'h0;
      for (int k = 0; k < 9; k++)
      begin
         hs(4 * k);
         chk("event copy", rows[k][25:0], copy & 26'h3e0000f);
      end
      $display("command rows done");
      hs(32'h24);
      repeat (8) @(negedge clock_i);
      chk("waiting fetch", 1'b0, req);
      @(posedge clock_i);
      src[1] <= 1'b1;
      lat <= 2'h3;
      changed <= 11'h005;
      hs(32'h28);
      chk("cleared copy", 1'b0, copy[1]);
      hs(32'h2c);
      chk("upload strobe", 11'h005, strobe);
      repeat (8) @(negedge clock_i);
      chk("waiting fetch", 1'b0, req);
      chk("waiting address", 32'h30, addr);
      @(posedge clock_i);
      src[1] <= 1'b0;
      @(posedge clock_i);
      src[1] <= 1'b1;
      hs(32'h34);
      chk("renewed copy", 1'b1, copy[1]);
      chk("late flag", 1'b1, late_flag[0]);
      hs(32'h38);
      $display("wait and upload done");
      @(posedge clock_i);
      late_clr <= 2'h1;
      limit0 <= 16'h0005;
      @(posedge clock_i);
      late_clr <= 2'h0;
      repeat (40) if (irq[0] !== 1'b1) @(negedge clock_i);
      chk("timeout request", 1'b1, irq[0]);
      @(negedge clock_i);
      chk("timeout flag", 1'b1, to_flag[0]);
      chk("late flag", 1'b0, late_flag[0]);
      $display("timeout done");
      @(posedge clock_i);
      to_clr <= 2'h1;
      addr1 <= 32'h00000080;
      en_set <= 2'h2;
      @(posedge clock_i);
      to_clr <= 2'h0;
      en_set <= 2'h0;
      hs(32'h80);
      chk("fetch owner", 1'b1, owner);
      chk("task enables", 2'h2, enable);
      chk("timeout flags", 2'h0, to_flag);
      @(posedge clock_i);
      en_clr <= 2'h2;
      @(posedge clock_i);
      en_clr <= 2'h0;
      @(negedge clock_i);
      chk("task enables", 2'h0, enable);
      $display("second task done");
      results();
   end
endmodule // test_sequencer_event_command_unit
